// *** core/discrete_cmd_pkg.sv ***
package discrete_cmd_pkg;
  // clock and time base
  localparam int CLK_MHZ = 100;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DEBOUNCE_US = 1000;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int ALARM_PULSE_NS = 40;
  localparam int ALARM_PULSE_CYCLES = (ALARM_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // engine speed at or above rated divided by this issues the auto reset (5 percent)
  localparam int AUTO_RESET_DIVISOR = 20;
  // discrete input positions
  localparam int IN_FUEL_SHIFT = 0;
  localparam int IN_ALARM_RESET = 1;
  localparam int IN_SPEED_OVERRIDE = 2;
  localparam int IN_DYNAMICS2 = 3;
  localparam int IN_RAISE = 4;
  localparam int IN_LOWER = 5;
  localparam int IN_RATED = 6;
  localparam int IN_OPEN_TO_RUN = 7;
  localparam int NUM_INPUTS = 8;
  // register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_SHIFT_AMOUNT = 8'h08;
  localparam logic [7:0] OFS_SHIFT_TIME = 8'h0c;
  localparam logic [7:0] OFS_RAMP_RATE = 8'h10;
  localparam logic [7:0] OFS_MAX_SPEED = 8'h14;
  localparam logic [7:0] OFS_MIN_SPEED = 8'h18;
  localparam logic [7:0] OFS_RATED_SPEED = 8'h1c;
  localparam logic [7:0] OFS_IDLE_SPEED = 8'h20;
  localparam logic [7:0] OFS_ACCEL_STEP = 8'h24;
  localparam logic [7:0] OFS_DECEL_STEP = 8'h28;
  localparam logic [7:0] OFS_SPEED_REF = 8'h2c;
  // control fields
  localparam int CTL_SW_RESET = 0;
  localparam int CTL_AUTO_SPEED_RESET = 1;
  localparam int CTL_REMOTE_FAIL_SHUTDOWN = 2;
  // reset values and fuel levels
  localparam logic [15:0] RST_SHIFT_AMOUNT = 16'h0000;
  localparam logic [15:0] RST_SHIFT_TIME = 16'h0000;
  localparam logic [15:0] RST_RAMP_RATE = 16'h0001;
  localparam logic [15:0] RST_MAX_SPEED = 16'hffff;
  localparam logic [15:0] RST_MIN_SPEED = 16'h0000;
  localparam logic [15:0] RST_RATED_SPEED = 16'h0000;
  localparam logic [15:0] RST_IDLE_SPEED = 16'h0000;
  localparam logic [15:0] RST_ACCEL_STEP = 16'h0001;
  localparam logic [15:0] RST_DECEL_STEP = 16'h0001;
  localparam logic [15:0] FUEL_FULL_SCALE = 16'hffff;
  localparam logic [15:0] FUEL_ZERO = 16'h0000;
  typedef enum {REF_IDLE, REF_ACCEL, REF_HOLD} ref_mode_t;
endpackage

// *** core/discrete_command_inputs.sv ***
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - contact voltage present means input true
// - status light follows each valid true input
// - shift input adds offset for set duration
// - shift false zeroes offset, clears timer
// - reset clears only alarms currently normal
// - reset is short pulse, rearm on release
// - input and software reset act in parallel
// - auto reset at power up, 5% speed
// - override suppresses speed loss shutdown
// - no override: shutdown when both sensors lost
// - dynamics input selects second dynamic set
// - raise ramps reference up to maximum
// - lower or rated off disables raise
// - lower ramps reference down to minimum
// - rated off disables lower
// - raise and lower together select remote
// - rated true ramps to rated, enables commands
// - rated false ramps to idle, disables commands
// - open-to-run false sets minimum fuel full
// - open-to-run true forces fuel demand zero
// - remote signal low ramps to minimum, or shutdown
module discrete_command_inputs #(
  parameter int DEBOUNCE_CYCLES = discrete_cmd_pkg::DEBOUNCE_CYCLES,
  parameter int TICK_CYCLES = discrete_cmd_pkg::TICK_CYCLES,
  parameter int NUM_ALARMS = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] contact_in,
  input wire logic [NUM_ALARMS-1:0] alarm_cond_normal,
  input wire logic speed1_lost,
  input wire logic speed2_lost,
  input wire logic [15:0] engine_speed,
  input wire logic [15:0] remote_ref,
  input wire logic remote_ref_low,
  output logic [7:0] indicator,
  output logic [NUM_ALARMS-1:0] alarm_clear,
  output logic [15:0] fuel_limit_offset,
  output logic speed_loss_shutdown,
  output logic fuel_rise_no_speed,
  output logic dynamics_set2,
  output logic [15:0] speed_ref,
  output logic remote_ref_active,
  output logic remote_fail_shutdown,
  output logic [15:0] min_fuel,
  output logic fuel_force_zero
);
  localparam int DW = $clog2(DEBOUNCE_CYCLES + 1);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int PW = $clog2(discrete_cmd_pkg::ALARM_PULSE_CYCLES + 1);
  // refuse sizes that the counters and the alarm mask cannot serve
  if (DEBOUNCE_CYCLES < 1 || TICK_CYCLES < 1 || NUM_ALARMS < 1 || NUM_ALARMS > 16) begin : g_check
    $error("unsupported parameter values");
  end
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic [7:0] cond;
  logic [2:0] control;
  logic [15:0] shift_amount;
  logic [15:0] shift_time;
  logic [15:0] ramp_rate;
  logic [15:0] max_speed;
  logic [15:0] min_speed;
  logic [15:0] rated_speed;
  logic [15:0] idle_speed;
  logic [15:0] accel_step;
  logic [15:0] decel_step;
  logic sw_reset;
  logic [TW-1:0] tick_cnt;
  logic tick;

  // two-flop synchroniser; only sync2 is looked at downstream
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
    end else begin
      sync1 <= contact_in;
      sync2 <= sync1;
    end
  end

  // per input debounce: a level must hold for the whole window to be believed
  for (genvar i = 0; i < discrete_cmd_pkg::NUM_INPUTS; i++) begin : g_deb
    logic [DW-1:0] cnt;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt <= '0;
        cond[i] <= 1'b0;
      end else if (sync2[i] == cond[i]) begin
        cnt <= '0;
      end else if (cnt == DW'(DEBOUNCE_CYCLES - 1)) begin
        cnt <= '0;
        cond[i] <= sync2[i];
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  // indicators only show the debounced state, so contact bounce never flickers them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      indicator <= 8'h00;
    end else begin
      indicator <= cond;
    end
  end

  // millisecond time base for ramps and the shift timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
    end else if (tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end
  assign tick = (tick_cnt == TW'(TICK_CYCLES - 1));

  // apb slave: zero wait states, read data captured in the setup cycle
  wire setup = psel && !penable;
  wire wr = psel && penable && pwrite;
  logic mapped;
  logic [31:0] rd_mux;
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      discrete_cmd_pkg::OFS_CONTROL: rd_mux = {29'h0, control[2:1], 1'b0};
      discrete_cmd_pkg::OFS_STATUS: rd_mux = {19'h0, fuel_force_zero, remote_fail_shutdown,
        remote_ref_active, speed_loss_shutdown, |fuel_limit_offset, cond};
      discrete_cmd_pkg::OFS_SHIFT_AMOUNT: rd_mux = {16'h0, shift_amount};
      discrete_cmd_pkg::OFS_SHIFT_TIME: rd_mux = {16'h0, shift_time};
      discrete_cmd_pkg::OFS_RAMP_RATE: rd_mux = {16'h0, ramp_rate};
      discrete_cmd_pkg::OFS_MAX_SPEED: rd_mux = {16'h0, max_speed};
      discrete_cmd_pkg::OFS_MIN_SPEED: rd_mux = {16'h0, min_speed};
      discrete_cmd_pkg::OFS_RATED_SPEED: rd_mux = {16'h0, rated_speed};
      discrete_cmd_pkg::OFS_IDLE_SPEED: rd_mux = {16'h0, idle_speed};
      discrete_cmd_pkg::OFS_ACCEL_STEP: rd_mux = {16'h0, accel_step};
      discrete_cmd_pkg::OFS_DECEL_STEP: rd_mux = {16'h0, decel_step};
      discrete_cmd_pkg::OFS_SPEED_REF: rd_mux = {16'h0, speed_ref};
      default: mapped = 1'b0;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // configuration registers; the software reset bit is write-one pulse, never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= 3'h0;
      sw_reset <= 1'b0;
      shift_amount <= discrete_cmd_pkg::RST_SHIFT_AMOUNT;
      shift_time <= discrete_cmd_pkg::RST_SHIFT_TIME;
      ramp_rate <= discrete_cmd_pkg::RST_RAMP_RATE;
      max_speed <= discrete_cmd_pkg::RST_MAX_SPEED;
      min_speed <= discrete_cmd_pkg::RST_MIN_SPEED;
      rated_speed <= discrete_cmd_pkg::RST_RATED_SPEED;
      idle_speed <= discrete_cmd_pkg::RST_IDLE_SPEED;
      accel_step <= discrete_cmd_pkg::RST_ACCEL_STEP;
      decel_step <= discrete_cmd_pkg::RST_DECEL_STEP;
    end else begin
      sw_reset <= wr && paddr == discrete_cmd_pkg::OFS_CONTROL &&
        pwdata[discrete_cmd_pkg::CTL_SW_RESET];
      if (wr) begin
        case (paddr)
          discrete_cmd_pkg::OFS_CONTROL: control <= {pwdata[2:1], 1'b0};
          discrete_cmd_pkg::OFS_SHIFT_AMOUNT: shift_amount <= pwdata[15:0];
          discrete_cmd_pkg::OFS_SHIFT_TIME: shift_time <= pwdata[15:0];
          discrete_cmd_pkg::OFS_RAMP_RATE: ramp_rate <= pwdata[15:0];
          discrete_cmd_pkg::OFS_MAX_SPEED: max_speed <= pwdata[15:0];
          discrete_cmd_pkg::OFS_MIN_SPEED: min_speed <= pwdata[15:0];
          discrete_cmd_pkg::OFS_RATED_SPEED: rated_speed <= pwdata[15:0];
          discrete_cmd_pkg::OFS_IDLE_SPEED: idle_speed <= pwdata[15:0];
          discrete_cmd_pkg::OFS_ACCEL_STEP: accel_step <= pwdata[15:0];
          discrete_cmd_pkg::OFS_DECEL_STEP: decel_step <= pwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  // fuel limit shift: offset while input true and timer not yet run out
  logic [15:0] shift_ms;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_ms <= 16'h0000;
      fuel_limit_offset <= 16'h0000;
    end else if (!cond[discrete_cmd_pkg::IN_FUEL_SHIFT]) begin
      shift_ms <= 16'h0000;
      fuel_limit_offset <= 16'h0000;
    end else begin
      if (tick && shift_ms < shift_time) begin
        shift_ms <= shift_ms + 16'h0001;
      end
      fuel_limit_offset <= (shift_ms < shift_time) ? shift_amount : 16'h0000;
    end
  end

  // alarm reset sources; edge on the conditioned input only, so one closure = one pulse
  logic reset_prev;
  logic power_up;
  logic speed_prev_hi;
  logic [PW-1:0] pulse_cnt;
  // wide enough that full-scale speed times the divisor cannot wrap and miss the 5% point
  wire [20:0] speed_x20 = 21'(engine_speed) * 21'(discrete_cmd_pkg::AUTO_RESET_DIVISOR);
  wire speed_hi = speed_x20 >= 21'(rated_speed) && rated_speed != 16'h0000;
  wire reset_edge = cond[discrete_cmd_pkg::IN_ALARM_RESET] && !reset_prev;
  wire auto_speed = control[discrete_cmd_pkg::CTL_AUTO_SPEED_RESET] && speed_hi && !speed_prev_hi;
  wire reset_req = reset_edge || sw_reset || power_up || auto_speed;
  wire pulse_on = (pulse_cnt != '0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_prev <= 1'b0;
      power_up <= 1'b1;
      speed_prev_hi <= 1'b0;
    end else begin
      reset_prev <= cond[discrete_cmd_pkg::IN_ALARM_RESET];
      power_up <= 1'b0;
      speed_prev_hi <= speed_hi;
    end
  end
  // fixed-length pulse; a held contact cannot stretch it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt <= '0;
    end else if (reset_req && !pulse_on) begin
      pulse_cnt <= PW'(discrete_cmd_pkg::ALARM_PULSE_CYCLES);
    end else if (pulse_on) begin
      pulse_cnt <= pulse_cnt - 1'b1;
    end
  end
  // alarms whose condition is not normal stay latched through the pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_clear <= '0;
    end else begin
      alarm_clear <= pulse_on ? alarm_cond_normal : '0;
    end
  end
  // speed sensing loss and dynamics selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_loss_shutdown <= 1'b0;
      fuel_rise_no_speed <= 1'b0;
      dynamics_set2 <= 1'b0;
    end else begin
      speed_loss_shutdown <= !cond[discrete_cmd_pkg::IN_SPEED_OVERRIDE] &&
        speed1_lost && speed2_lost;
      fuel_rise_no_speed <= cond[discrete_cmd_pkg::IN_SPEED_OVERRIDE];
      dynamics_set2 <= cond[discrete_cmd_pkg::IN_DYNAMICS2];
    end
  end
  // minimum fuel function: open contact lets other loops govern, closed stops fuel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      min_fuel <= discrete_cmd_pkg::FUEL_FULL_SCALE;
      fuel_force_zero <= 1'b0;
    end else if (cond[discrete_cmd_pkg::IN_OPEN_TO_RUN]) begin
      min_fuel <= discrete_cmd_pkg::FUEL_ZERO;
      fuel_force_zero <= 1'b1;
    end else begin
      min_fuel <= discrete_cmd_pkg::FUEL_FULL_SCALE;
      fuel_force_zero <= 1'b0;
    end
  end
  // move cur toward target by at most step, never overshooting
  function automatic logic [15:0] step_toward(input logic [15:0] cur, input logic [15:0] target,
                                              input logic [15:0] step);
    logic [16:0] sum;
    sum = 17'(cur) + 17'(step);
    if (cur < target) begin
      step_toward = (sum >= 17'(target)) ? target : sum[15:0];
    end else if (cur - target <= step) begin
      step_toward = target;
    end else begin
      step_toward = cur - step;
    end
  endfunction
  // speed reference; rated acts as permissive for raise, lower and remote
  discrete_cmd_pkg::ref_mode_t ref_mode;
  wire rated = cond[discrete_cmd_pkg::IN_RATED];
  wire raise = cond[discrete_cmd_pkg::IN_RAISE];
  wire lower = cond[discrete_cmd_pkg::IN_LOWER];
  wire remote_sel = rated && raise && lower;
  wire raise_cmd = rated && raise && !lower;
  wire lower_cmd = rated && lower && !raise;
  wire [15:0] remote_tgt = (remote_ref > max_speed) ? max_speed :
    (remote_ref < min_speed) ? min_speed : remote_ref;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_mode <= discrete_cmd_pkg::REF_IDLE;
      speed_ref <= discrete_cmd_pkg::RST_IDLE_SPEED;
    end else begin
      case (ref_mode)
        discrete_cmd_pkg::REF_IDLE: begin
          if (rated) begin
            ref_mode <= discrete_cmd_pkg::REF_ACCEL;
          end else if (tick) begin
            speed_ref <= step_toward(speed_ref, idle_speed, decel_step);
          end
        end
        discrete_cmd_pkg::REF_ACCEL: begin
          if (!rated) begin
            ref_mode <= discrete_cmd_pkg::REF_IDLE;
          end else if (raise || lower) begin
            ref_mode <= discrete_cmd_pkg::REF_HOLD;
          end else if (tick) begin
            speed_ref <= step_toward(speed_ref, rated_speed, accel_step);
            if (speed_ref == rated_speed) begin
              ref_mode <= discrete_cmd_pkg::REF_HOLD;
            end
          end
        end
        discrete_cmd_pkg::REF_HOLD: begin
          if (!rated) begin
            ref_mode <= discrete_cmd_pkg::REF_IDLE;
          end else if (tick && remote_sel && remote_ref_low) begin
            speed_ref <= step_toward(speed_ref, min_speed, decel_step);
          end else if (tick && remote_sel) begin
            speed_ref <= step_toward(speed_ref, remote_tgt, ramp_rate);
          end else if (tick && raise_cmd) begin
            speed_ref <= step_toward(speed_ref, max_speed, ramp_rate);
          end else if (tick && lower_cmd) begin
            speed_ref <= step_toward(speed_ref, min_speed, ramp_rate);
          end
        end
        default: ref_mode <= discrete_cmd_pkg::REF_IDLE;
      endcase
    end
  end

  // remote status outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remote_ref_active <= 1'b0;
      remote_fail_shutdown <= 1'b0;
    end else begin
      remote_ref_active <= remote_sel;
      remote_fail_shutdown <= remote_sel && remote_ref_low &&
        control[discrete_cmd_pkg::CTL_REMOTE_FAIL_SHUTDOWN];
    end
  end

  // checks
  a_light_follow: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 indicator == $past(cond)) else $error("indicator does not follow input");
  a_shift_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !cond[discrete_cmd_pkg::IN_FUEL_SHIFT] |=> fuel_limit_offset == '0 && shift_ms == '0)
    else $error("shift offset not cleared");
  a_shift_apply: assert property (@(posedge pclk) disable iff (!presetn)
    cond[discrete_cmd_pkg::IN_FUEL_SHIFT] && shift_ms < shift_time
    |=> fuel_limit_offset == $past(shift_amount)) else $error("shift offset not applied");
  a_pulse_len: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(pulse_on) |-> pulse_on[*4] ##1 !pulse_on) else $error("reset pulse length wrong");
  a_clear_gated: assert property (@(posedge pclk) disable iff (!presetn)
    (alarm_clear & ~$past(alarm_cond_normal)) == '0) else $error("abnormal alarm cleared");
  a_edge_reset: assert property (@(posedge pclk) disable iff (!presetn)
    reset_edge && !pulse_on |=> pulse_on ##1 alarm_clear == $past(alarm_cond_normal))
    else $error("reset input ignored");
  a_loss_trip: assert property (@(posedge pclk) disable iff (!presetn)
    speed1_lost && speed2_lost && !cond[discrete_cmd_pkg::IN_SPEED_OVERRIDE]
    |=> speed_loss_shutdown) else $error("no shutdown on speed loss");
  a_override: assert property (@(posedge pclk) disable iff (!presetn)
    cond[discrete_cmd_pkg::IN_SPEED_OVERRIDE] |=> !speed_loss_shutdown && fuel_rise_no_speed)
    else $error("override not honoured");
  a_fuel_zero: assert property (@(posedge pclk) disable iff (!presetn)
    cond[discrete_cmd_pkg::IN_OPEN_TO_RUN] |=> min_fuel == discrete_cmd_pkg::FUEL_ZERO)
    else $error("fuel not forced to zero");
  a_no_raise: assert property (@(posedge pclk) disable iff (!presetn)
    !rated && speed_ref >= idle_speed |=> speed_ref <= $past(speed_ref))
    else $error("reference rose without rated");
endmodule // discrete_command_inputs
`default_nettype wire

// *** verif/contact_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// switch and relay contacts on the far side of the command inputs
module contact_model (
  input wire logic pclk,
  output logic [7:0] contact_in
);
  // all contacts open at power up, override contact included
  initial contact_in = 8'h00;

  // a contact changes just after an edge; high means voltage present
  task automatic drive(input logic [7:0] v);
    @(posedge pclk);
    contact_in <= v;
  endtask

  // a bounce shorter than the debounce window, then back to rest
  task automatic bounce(input logic [7:0] m, input int n);
    logic [7:0] rest;
    rest = contact_in;
    @(posedge pclk);
    contact_in <= rest ^ m;
    repeat (n) @(posedge pclk);
    contact_in <= rest;
  endtask
endmodule // contact_model
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, contacts, indicator, alarm_clear, cond_ok;
  logic [31:0] pwdata, prdata, rd;
  logic speed1_lost, speed2_lost, remote_ref_low, remote_ref_active, remote_fail_shutdown;
  logic [15:0] engine_speed, remote_ref, fuel_limit_offset, speed_ref, min_fuel;
  logic speed_loss_shutdown, fuel_rise_no_speed, dynamics_set2, fuel_force_zero;
  int num_errors = 0;
  int n_tests = 0;
  int n;

  contact_model u_contacts (.pclk(pclk), .contact_in(contacts));

  // short debounce and tick so ramps finish in a few hundred cycles
  discrete_command_inputs #(.DEBOUNCE_CYCLES(4), .TICK_CYCLES(8), .NUM_ALARMS(8)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .contact_in(contacts), .alarm_cond_normal(cond_ok), .speed1_lost(speed1_lost),
    .speed2_lost(speed2_lost), .engine_speed(engine_speed), .remote_ref(remote_ref),
    .remote_ref_low(remote_ref_low), .indicator(indicator), .alarm_clear(alarm_clear),
    .fuel_limit_offset(fuel_limit_offset), .speed_loss_shutdown(speed_loss_shutdown),
    .fuel_rise_no_speed(fuel_rise_no_speed), .dynamics_set2(dynamics_set2),
    .speed_ref(speed_ref), .remote_ref_active(remote_ref_active),
    .remote_fail_shutdown(remote_fail_shutdown), .min_fuel(min_fuel),
    .fuel_force_zero(fuel_force_zero));

  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic print_verdict;
    if (num_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // a wait that ran out of its bound ends the run
  task automatic bound(input int i);
    if (i >= 1000) begin
      num_errors++;
      print_verdict();
    end
  endtask

  // one apb transfer: setup, then access held until pready at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 1000; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    bound(i);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_ind(input logic [7:0] v);
    int i;
    for (i = 0; i < 1000 && indicator !== v; i++) begin
      @(posedge pclk);
      #1;
    end
    bound(i);
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task automatic wait_ref(input logic [15:0] v);
    int i;
    for (i = 0; i < 1000 && speed_ref !== v; i++) begin
      @(posedge pclk);
      #1;
    end
    check(speed_ref, v);
    bound(i);
  endtask

  // counts cycles of a clear pattern; any other nonzero pattern spoils the count
  task automatic count_clear(input logic [7:0] v, input int win);
    n = 0;
    repeat (win) begin
      @(posedge pclk);
      #1;
      if (alarm_clear === v) n++;
      else if (alarm_clear !== 8'h00) n += 100;
    end
  endtask

  task automatic hold(input logic [15:0] v);
    repeat (30) @(posedge pclk);
    #1;
    check(speed_ref, v);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {speed1_lost, speed2_lost, engine_speed, remote_ref, remote_ref_low} = '0;
    cond_ok = 8'ha5;
    @(posedge pclk);
    #1;
    check(min_fuel, 16'hffff);
    @(posedge pclk);
    presetn <= 1'b1;
    count_clear(8'ha5, 20);
    check(n, 4);
    apb(1'b0, discrete_cmd_pkg::OFS_MAX_SPEED, 32'h0);
    check(rd, 32'h0000ffff);
    apb(1'b1, 8'h30, 32'h5);
    check(err, 1'b1);
    apb(1'b0, 8'h30, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, discrete_cmd_pkg::OFS_SHIFT_AMOUNT, 32'h12);
    apb(1'b1, discrete_cmd_pkg::OFS_SHIFT_TIME, 32'h2);
    apb(1'b1, discrete_cmd_pkg::OFS_RATED_SPEED, 32'h10);
    apb(1'b1, discrete_cmd_pkg::OFS_ACCEL_STEP, 32'h2);
    apb(1'b1, discrete_cmd_pkg::OFS_MAX_SPEED, 32'h14);
    apb(1'b1, discrete_cmd_pkg::OFS_MIN_SPEED, 32'h0c);
    apb(1'b1, discrete_cmd_pkg::OFS_IDLE_SPEED, 32'h4);
    apb(1'b0, discrete_cmd_pkg::OFS_MIN_SPEED, 32'h0);
    check(rd, 32'h0000000c);
    u_contacts.bounce(8'h08, 2);
    repeat (10) @(posedge pclk);
    #1;
    check(indicator, 8'h00);
    u_contacts.drive(8'h08);
    wait_ind(8'h08);
    check(dynamics_set2, 1'b1);
    @(posedge pclk);
    speed1_lost <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    check(speed_loss_shutdown, 1'b0);
    @(posedge pclk);
    speed2_lost <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    check(speed_loss_shutdown, 1'b1);
    u_contacts.drive(8'h04);
    wait_ind(8'h04);
    check({speed_loss_shutdown, fuel_rise_no_speed, dynamics_set2}, 3'b010);
    u_contacts.drive(8'h80);
    wait_ind(8'h80);
    check({speed_loss_shutdown, fuel_force_zero, min_fuel}, {2'b11, 16'h0000});
    apb(1'b0, discrete_cmd_pkg::OFS_STATUS, 32'h0);
    check(rd, 32'h00001280);
    u_contacts.drive(8'h01);
    wait_ind(8'h01);
    check({min_fuel, fuel_limit_offset}, 32'hffff0012);
    repeat (40) @(posedge pclk);
    #1;
    check(fuel_limit_offset, 16'h0);
    u_contacts.drive(8'h00);
    wait_ind(8'h00);
    u_contacts.drive(8'h01);
    wait_ind(8'h01);
    check(fuel_limit_offset, 16'h12);
    u_contacts.drive(8'h00);
    wait_ind(8'h00);
    check(fuel_limit_offset, 16'h0);
    @(posedge pclk);
    cond_ok <= 8'h3c;
    for (int k = 0; k < 2; k++) begin
      u_contacts.drive(8'h02);
      count_clear(8'h3c, 40);
      check(n, 4);
      u_contacts.drive(8'h00);
      wait_ind(8'h00);
    end
    apb(1'b1, discrete_cmd_pkg::OFS_CONTROL, 32'h1);
    count_clear(8'h3c, 20);
    check(n, 4);
    apb(1'b1, discrete_cmd_pkg::OFS_CONTROL, 32'h2);
    count_clear(8'h3c, 10);
    check(n, 0);
    @(posedge pclk);
    engine_speed <= 16'h0001;
    count_clear(8'h3c, 20);
    check(n, 4);
    u_contacts.drive(8'h40);
    wait_ref(16'h10);
    apb(1'b0, discrete_cmd_pkg::OFS_SPEED_REF, 32'h0);
    check(rd, 32'h00000010);
    u_contacts.drive(8'h50);
    wait_ref(16'h14);
    hold(16'h14);
    u_contacts.drive(8'h60);
    wait_ref(16'h0c);
    @(posedge pclk);
    remote_ref <= 16'h0e;
    u_contacts.drive(8'h70);
    wait_ref(16'h0e);
    check(remote_ref_active, 1'b1);
    @(posedge pclk);
    remote_ref_low <= 1'b1;
    wait_ref(16'h0c);
    check(remote_fail_shutdown, 1'b0);
    apb(1'b1, discrete_cmd_pkg::OFS_CONTROL, 32'h4);
    repeat (2) @(posedge pclk);
    #1;
    check(remote_fail_shutdown, 1'b1);
    u_contacts.drive(8'h10);
    wait_ref(16'h04);
    check({remote_ref_active, remote_fail_shutdown}, 2'b00);
    hold(16'h04);
    u_contacts.drive(8'h20);
    hold(16'h04);
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
